// [tsf_framer.sv]
// Purpose: Transport-stream input sampling, packet framing and framing status outputs
// Assumes: REF_CLK is the processing clock; the input clock pin is slow enough to oversample
// Notes: The modulation datapath is reduced to nibble mapping of the framed bytes
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides
module tsf_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [AW:0] level
);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wr_ptr;            // Write pointer with wrap bit
  logic [AW:0] rd_ptr;            // Read pointer with wrap bit
  logic push;                     // Word taken in
  logic pop;                      // Word handed out

  // Honest full and empty from the wrap bit
  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != (AW + 1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule // tsf_fifo

module tsf_framer
  import tsf_pkg::*;
#(
  parameter int TRACK_STEPS = 3,      // Sync hits needed for lock
  parameter logic [7:0] GAP_BYTES = 8'h00,  // Extra FRAME_START_OUT cycles per frame head
  parameter int FIFO_DEPTH = 4        // Input FIFO words
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Transport source pins
  input wire logic INPUT_CLOCK,
  input wire logic [7:0] TS_DATA_IN,
  input wire logic TS_VALID_IN,
  input wire logic TS_ERROR_IN,
  input wire logic PACKET_START_IN,
  input wire logic SEQUENCE_RESTART_IN,
  output logic TS_READY,
  // Static configuration pins
  input wire logic SERIAL_MODE,
  input wire logic FORCED_SYNC,
  input wire logic [1:0] PLL_MODE,
  // Register access
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  // Processing outputs
  output logic SYMBOL_CLOCK,
  output logic [9:0] INPHASE_DIGITAL_OUT,
  output logic [9:0] QUADRATURE_DIGITAL_OUT,
  // Framing status
  output logic FRAME_START_OUT,
  output logic FIRST_BLOCK_OUT,
  output logic SYNC_LOCKED,
  output logic FIFO_COLLISION_ALARM
);

  localparam int AW = $clog2(FIFO_DEPTH);

  tsf_pins_t pins;          // Raw pin group
  tsf_pins_t pins_s1;       // First synchroniser stage
  tsf_pins_t pins_s2;       // Second synchroniser stage
  logic [3:0] cfg_s1;       // Config pins, first stage
  logic [3:0] cfg_s2;       // Config pins, second stage
  logic clk_prev;           // Previous input clock level
  logic restart_prev;       // Restart level at last input clock rise
  logic serial;             // Serial mode selected
  logic forced;             // Packet-start forced sync selected
  logic nco_mode;           // Oscillator PLL mode selected
  logic input_clock_rise;          // Input clock rising edge seen
  logic take;               // Valid bit or byte sampled
  logic [2:0] bit_cnt;      // Serial bit position
  logic [6:0] shreg;        // Serial bits gathered so far
  logic pstart_cap;         // Packet start seen at first bit
  logic err_cap;            // Error flag seen at first bit
  logic cur_pstart;         // Packet start of the current byte
  logic cur_err;            // Error flag of the current byte
  logic byte_strobe;        // Whole byte assembled
  logic [7:0] new_byte;     // Assembled byte
  logic [7:0] pos;          // Byte position in packet
  logic aligned;            // Forced mode has seen a packet start
  tsf_sync_t sync_state;    // Sync word tracker
  tsf_sync_t next_sync_state;
  logic [7:0] steps;        // Consecutive sync hits
  logic sync_match;         // Byte is a sync byte
  logic is_head;            // Byte starts a packet
  logic [2:0] pkt_idx;      // Packet index within frame
  logic [2:0] next_pkt_idx;
  logic restart_pend;       // Restart edge awaiting frame head
  logic restart_fall;       // Restart falling edge
  logic first_head;         // This head follows a restart
  logic pkt_err;            // Error flag latched at packet head
  tsf_word_t wr_word;       // Word into FIFO
  logic wr_valid;           // FIFO write request
  logic wr_ready;           // FIFO has room
  tsf_word_t rd_word;       // Word out of FIFO
  logic rd_valid;           // FIFO holds a word
  logic [AW:0] fifo_level;  // FIFO fill level
  logic [1:0] phase;        // Symbol phase
  logic tick;               // Last phase: symbol boundary
  logic primed;             // FIFO has been written once
  logic collision;          // Pointer collision this cycle
  logic coll_hold;          // Collision held until symbol tick
  logic alarm_s1;           // First symbol-clock alarm stage
  logic [7:0] fs_cnt;       // Remaining frame-start cycles
  logic [7:0] threshold;    // FIFO measurement threshold
  logic below_thres;        // FIFO level at or below threshold

  assign pins = '{clk: INPUT_CLOCK, data: TS_DATA_IN, valid: TS_VALID_IN, err: TS_ERROR_IN,
                  pstart: PACKET_START_IN, srestart: SEQUENCE_RESTART_IN};

  // Two-stage synchroniser for all pins from the source side
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      clk_prev <= 1'b0;
    end else begin
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      cfg_s1 <= {SERIAL_MODE, FORCED_SYNC, PLL_MODE};
      cfg_s2 <= cfg_s1;
      clk_prev <= pins_s2.clk;
    end
  end

  // Decoded configuration
  assign serial = cfg_s2[3];
  assign forced = cfg_s2[2];
  assign nco_mode = (cfg_s2[1:0] == TSF_PLL_NCO);

  // Sample point is the rising input clock edge, gated by valid
  assign input_clock_rise = pins_s2.clk & ~clk_prev;
  assign take = input_clock_rise & pins_s2.valid;
  assign restart_fall = input_clock_rise & restart_prev & ~pins_s2.srestart;

  // Byte assembly: serial takes bit 0 MSB first, parallel the whole bus
  assign new_byte = serial ? {shreg, pins_s2.data[0]} : pins_s2.data;
  assign byte_strobe = take & (~serial | (bit_cnt == TSF_BIT_LAST));
  assign cur_pstart = (bit_cnt == '0) ? pins_s2.pstart : pstart_cap;
  assign cur_err = (bit_cnt == '0) ? pins_s2.err : err_cap;

  // Serial bit counter and shifter; parallel keeps the counter at zero
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bit_cnt <= '0;
      shreg <= '0;
      pstart_cap <= 1'b0;
      err_cap <= 1'b0;
    end else if (take) begin
      if (bit_cnt == '0) begin
        pstart_cap <= pins_s2.pstart;
        err_cap <= pins_s2.err;
      end
      if (serial) begin
        shreg <= {shreg[5:0], pins_s2.data[0]};
        bit_cnt <= bit_cnt + 1'b1;
      end else begin
        bit_cnt <= '0;
      end
    end
  end

  // Sync byte recognition and packet head decision
  assign sync_match = (new_byte == TSF_SYNC_BYTE) | (new_byte == TSF_SYNC_INV);
  always_comb begin
    if (forced) begin
      is_head = cur_pstart;
    end else if (sync_state == TSF_HUNT) begin
      is_head = sync_match;
    end else begin
      is_head = (pos == '0);
    end
  end

  // Sync word tracker for detection mode
  always_comb begin
    next_sync_state = sync_state;
    case (sync_state)
      TSF_HUNT: begin
        if (sync_match) begin
          next_sync_state = (TRACK_STEPS <= 1) ? TSF_LOCK : TSF_TRACK;
        end
      end
      TSF_TRACK: begin
        if (pos == '0) begin
          if (!sync_match) begin
            next_sync_state = TSF_HUNT;
          end else if (steps >= 8'(TRACK_STEPS - 1)) begin
            next_sync_state = TSF_LOCK;
          end
        end
      end
      TSF_LOCK: begin
        if ((pos == '0) && !sync_match) begin
          next_sync_state = TSF_TRACK;  // One miss keeps position
        end
      end
      default: next_sync_state = TSF_HUNT;
    endcase
  end

  // Tracker state, position and hit count
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_state <= TSF_HUNT;
      pos <= '0;
      steps <= '0;
      aligned <= 1'b0;
    end else if (forced) begin
      sync_state <= TSF_HUNT;
      steps <= '0;
      if (byte_strobe) begin
        if (is_head) begin
          aligned <= 1'b1;
          pos <= 8'h01;
        end else begin
          pos <= (pos == TSF_PKT_LAST) ? '0 : pos + 1'b1;
        end
      end
    end else if (byte_strobe) begin
      aligned <= 1'b0;
      sync_state <= next_sync_state;
      pos <= (is_head || pos != TSF_PKT_LAST) ? ((is_head ? 8'h00 : pos) + 1'b1) : '0;
      if (is_head && sync_match && sync_state != TSF_LOCK) begin
        steps <= (sync_state == TSF_HUNT) ? 8'h01 : steps + 1'b1;
      end else if (is_head && !sync_match) begin
        steps <= '0;
      end
    end
  end

  // Packet index within frame; restart zeroes it, otherwise free-running
  assign next_pkt_idx = (restart_pend | restart_fall) ? '0 :
                        ((pkt_idx == TSF_PKT_IDX_LAST) ? '0 : pkt_idx + 1'b1);
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pkt_idx <= TSF_PKT_IDX_LAST;
      restart_prev <= 1'b0;
      restart_pend <= 1'b0;
      pkt_err <= 1'b0;
    end else begin
      if (input_clock_rise) begin
        restart_prev <= pins_s2.srestart;
      end
      // A fall in the same cycle as a head still restarts this head
      if (byte_strobe && is_head && wr_valid) begin
        pkt_idx <= next_pkt_idx;
        restart_pend <= 1'b0;
        pkt_err <= cur_err;
      end else if (restart_fall) begin
        restart_pend <= 1'b1;
      end
    end
  end

  // FIFO word: sync insertion in forced mode, error bit in second byte
  assign first_head = restart_pend | restart_fall;
  assign wr_valid = byte_strobe & (forced ? (aligned | is_head) : (sync_state != TSF_HUNT
                    | sync_match));
  always_comb begin
    wr_word.data = new_byte;
    wr_word.frame_head = 1'b0;
    wr_word.first = 1'b0;
    if (is_head) begin
      wr_word.frame_head = (next_pkt_idx == '0);
      wr_word.first = first_head;
      if (forced) begin
        wr_word.data = (next_pkt_idx == '0) ? TSF_SYNC_INV : TSF_SYNC_BYTE;
      end
    end else if ((pos == TSF_POS_TEI) && pkt_err) begin
      wr_word.data[TSF_TEI_BIT] = 1'b1;
    end
  end

  // Input FIFO between framing and symbol-rate drain
  tsf_fifo #(
    .WIDTH($bits(tsf_word_t)),
    .DEPTH(FIFO_DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .in_valid(wr_valid),
    .in_data(wr_word),
    .in_ready(wr_ready),
    .out_valid(rd_valid),
    .out_ready(tick),
    .out_data(rd_word),
    .level(fifo_level)
  );

  // Symbol phase counter: processing clock divided by four
  assign tick = (phase == TSF_PH_LAST);
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase <= TSF_PH_LAST;  // First edge enters phase 0, so the first high lasts two cycles
      SYMBOL_CLOCK <= 1'b0;
    end else begin
      phase <= phase + 1'b1;
      SYMBOL_CLOCK <= ((phase + 1'b1) < TSF_PH_HIGH_END);
    end
  end

  // Collision: write into full FIFO or symbol read of an empty primed FIFO
  assign collision = (wr_valid & ~wr_ready) | (tick & ~rd_valid & primed);
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      primed <= 1'b0;
      coll_hold <= 1'b0;
      alarm_s1 <= 1'b0;
      FIFO_COLLISION_ALARM <= 1'b0;
    end else begin
      if (wr_valid) begin
        primed <= 1'b1;
      end
      if (tick) begin
        alarm_s1 <= coll_hold | collision;
        FIFO_COLLISION_ALARM <= alarm_s1;
        coll_hold <= 1'b0;
      end else if (collision) begin
        coll_hold <= 1'b1;
      end
    end
  end

  // Drain one word per symbol; I/Q and framing outputs on processing clock
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      INPHASE_DIGITAL_OUT <= '0;
      QUADRATURE_DIGITAL_OUT <= '0;
      FRAME_START_OUT <= 1'b0;
      FIRST_BLOCK_OUT <= 1'b0;
      fs_cnt <= '0;
    end else begin
      FIRST_BLOCK_OUT <= 1'b0;
      if (tick && rd_valid) begin
        INPHASE_DIGITAL_OUT <= {rd_word.data[7:4], 6'h00};
        QUADRATURE_DIGITAL_OUT <= {rd_word.data[3:0], 6'h00};
      end
      if (tick && rd_valid && rd_word.frame_head && !forced) begin
        FRAME_START_OUT <= 1'b1;
        fs_cnt <= GAP_BYTES;
        FIRST_BLOCK_OUT <= rd_word.first;
      end else if (forced) begin
        FRAME_START_OUT <= 1'b0;
        fs_cnt <= '0;
      end else if (fs_cnt != '0) begin
        fs_cnt <= fs_cnt - 1'b1;
      end else begin
        FRAME_START_OUT <= 1'b0;
      end
    end
  end

  // Lock status and source back-pressure
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SYNC_LOCKED <= 1'b0;
      TS_READY <= 1'b0;
    end else begin
      SYNC_LOCKED <= (sync_state == TSF_LOCK) & ~forced;
      TS_READY <= wr_ready;
    end
  end

  // Threshold comparison, meaningful only in oscillator mode
  assign below_thres = nco_mode & ((AW + 1 > 8) ? 1'b0 : ({{(8 - AW - 1){1'b0}}, fifo_level}
                       <= threshold));

  // Threshold register write
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      threshold <= TSF_THRESH_RST;
    end else if (REG_WR && (REG_ADDR == TSF_ADDR_THRESH)) begin
      threshold <= REG_WDATA;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= '0;
    end else begin
      case (REG_ADDR)
        TSF_ADDR_THRESH: REG_RDATA <= threshold;
        TSF_ADDR_STATUS: REG_RDATA <= {below_thres, nco_mode, SYNC_LOCKED,
                                       FIFO_COLLISION_ALARM, 4'(fifo_level)};
        default: REG_RDATA <= '0;
      endcase
    end
  end

endmodule // tsf_framer

// [tsf_framer_checker.sv]
// Purpose: Port-level assertions for the transport-stream framer
// Assumes: One REF_CLK domain, asynchronous active-low RSTN
// Notes: Attached by the bind at the foot of this file
`timescale 1ns/1ps
module tsf_framer_checker
  import tsf_pkg::*;
#(
  parameter logic [7:0] GAP_BYTES = 8'h00
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Watched pins
  input wire logic FORCED_SYNC,
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic SYMBOL_CLOCK,
  input wire logic FRAME_START_OUT,
  input wire logic FIRST_BLOCK_OUT,
  input wire logic SYNC_LOCKED,
  input wire logic FIFO_COLLISION_ALARM
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  logic [8:0] run; // Length of the current frame-start run

  // Count frame-start cycles
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) run <= 9'h000;
    else if (FRAME_START_OUT) run <= run + 9'h001;
    else run <= 9'h000;
  end

  AST_SYMCLK: assert property ($rose(SYMBOL_CLOCK) |=> SYMBOL_CLOCK ##1 !SYMBOL_CLOCK [*2]
    ##1 SYMBOL_CLOCK) else $error("symbol clock not a divide by four");
  AST_FSTART_FORCED: assert property (FORCED_SYNC |-> !FRAME_START_OUT)
    else $error("frame start high under forced sync");
  AST_LOCK_FORCED: assert property (FORCED_SYNC |-> !SYNC_LOCKED)
    else $error("sync lock high under forced sync");
  AST_FIRST: assert property (FIRST_BLOCK_OUT && !FORCED_SYNC |-> $rose(FRAME_START_OUT)
    ##1 !FIRST_BLOCK_OUT) else $error("first block not with frame start");
  AST_FSTART_WIDTH: assert property ($fell(FRAME_START_OUT) |-> run == {1'b0, GAP_BYTES} + 9'h001)
    else $error("frame start width wrong");
  AST_ALARM_HOLD: assert property ($changed(FIFO_COLLISION_ALARM) |=>
    $stable(FIFO_COLLISION_ALARM) [*3]) else $error("alarm not held for a symbol");
  AST_REG_READ: assert property (REG_WR && REG_ADDR == TSF_ADDR_THRESH ##1
    REG_ADDR == TSF_ADDR_THRESH |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("threshold read back wrong");
  AST_RESET_ZERO: assert property ($rose(RSTN) |-> !FRAME_START_OUT && !SYNC_LOCKED
    && !FIFO_COLLISION_ALARM && REG_RDATA == 8'h00) else $error("outputs not cleared");

  // Main scenarios
  cover property ($rose(FRAME_START_OUT));
  cover property ($rose(SYNC_LOCKED));
  cover property ($rose(FIRST_BLOCK_OUT));
endmodule // tsf_framer_checker

bind tsf_framer tsf_framer_checker #(.GAP_BYTES(GAP_BYTES)) tsf_framer_checker_i (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .FORCED_SYNC(FORCED_SYNC), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
  .SYMBOL_CLOCK(SYMBOL_CLOCK), .FRAME_START_OUT(FRAME_START_OUT),
  .FIRST_BLOCK_OUT(FIRST_BLOCK_OUT), .SYNC_LOCKED(SYNC_LOCKED),
  .FIFO_COLLISION_ALARM(FIFO_COLLISION_ALARM)
);

// [tsf_framer_tb_top.sv]
// Purpose: Self-checking bench of the transport-stream framer
// Assumes: Source model drives the transport pins, bench the rest
// Notes: Two frame-start gap bytes so the run width is three
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tsf_framer_tb_top;
  import tsf_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, serial_mode = 1'b0, forced_sync = 1'b0, reg_wr = 1'b0;
  logic [1:0] pll_mode = 2'h3;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, rdata, d;
  logic [9:0] i_out, q_out;
  logic [19:0] iq_prev;
  logic fso, first, locked, ev_prev_fs, ev_prev_fb;
  logic rdy, alarm, ev_prev_al;
  logic tclk, tval, terr, tps, tsr;
  logic [7:0] tdat;
  logic [7:0] seen[$];
  logic [7:0] exp_forced[6] = '{8'hb8, 8'h01, 8'h02, 8'h03, 8'h47, 8'h01};
  int num_errors = 0, checked = 0, fs_rises = 0, fb_rises = 0, cyc = 0, al_rises = 0;

  always #12.5 ref_clk = ~ref_clk;

  tsf_ts_source tsf_ts_source_i (.clk(ref_clk), .serial(serial_mode), .ts_clk(tclk),
    .ts_data(tdat), .ts_valid(tval), .ts_err(terr), .ts_pstart(tps), .ts_srestart(tsr));

  tsf_framer #(.TRACK_STEPS(3), .GAP_BYTES(8'h02), .FIFO_DEPTH(4)) tsf_framer_i (
    .REF_CLK(ref_clk), .RSTN(rst_n), .INPUT_CLOCK(tclk), .TS_DATA_IN(tdat),
    .TS_VALID_IN(tval), .TS_ERROR_IN(terr), .PACKET_START_IN(tps),
    .SEQUENCE_RESTART_IN(tsr), .TS_READY(rdy), .SERIAL_MODE(serial_mode),
    .FORCED_SYNC(forced_sync), .PLL_MODE(pll_mode), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RDATA(rdata), .SYMBOL_CLOCK(),
    .INPHASE_DIGITAL_OUT(i_out), .QUADRATURE_DIGITAL_OUT(q_out), .FRAME_START_OUT(fso),
    .FIRST_BLOCK_OUT(first), .SYNC_LOCKED(locked), .FIFO_COLLISION_ALARM(alarm));

  // Collect each new I/Q word and count status rises
  always @(posedge ref_clk) begin
    iq_prev <= {i_out, q_out};
    ev_prev_fs <= fso;
    ev_prev_fb <= first;
    ev_prev_al <= alarm;
    if (rst_n && {i_out, q_out} !== iq_prev) seen.push_back({i_out[9:6], q_out[9:6]});
    if (rst_n && fso && !ev_prev_fs) fs_rises++;
    if (rst_n && first && !ev_prev_fb) fb_rises++;
    if (rst_n && alarm && !ev_prev_al) al_rises++;
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset with the mode pins set meanwhile
  task automatic restart(input logic ser, frc);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    serial_mode <= ser;
    forced_sync <= frc;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    seen.delete();
    fs_rises = 0;
    fb_rises = 0;
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [5:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    v = rdata;
  endtask

  // Packet of n bytes numbered by index, one invalid byte after byte 3
  task automatic packet(input logic [7:0] head, input int n, input logic er, input int sr_at);
    for (int k = 0; k < n; k++) begin
      tsf_ts_source_i.send(k == 0 ? head : k[7:0], 1'b1, k == 0, er && k == 0, k == sr_at);
      if (k == 3) tsf_ts_source_i.send(8'hff, 1'b0, 1'b0, 1'b0, 1'b0);
    end
  endtask

  initial begin
    restart(1'b0, 1'b0);
    reg_read(TSF_ADDR_THRESH, d); `CHK(d, TSF_THRESH_RST)
    reg_write(TSF_ADDR_THRESH, 8'ha5);
    reg_write(6'h2a, 8'h3c);
    reg_read(TSF_ADDR_THRESH, d); `CHK(d, 8'ha5)
    reg_read(6'h2a, d); `CHK(d, 8'h00)
    foreach (exp_forced[j]) if (j < 3) begin
      @(posedge ref_clk) pll_mode <= (j == 2) ? 2'h3 : j[1:0];
      repeat (2) @(posedge ref_clk);
      reg_read(TSF_ADDR_STATUS, d); `CHK(d[6], (j == 2))
      `CHK(d[7], (j == 2))
    end
    packet(8'hb8, 188, 1'b1, -1);
    for (int p = 0; p < 3; p++) packet(8'h47, 188, 1'b0, -1);
    repeat (100) @(posedge ref_clk);
    `CHK(seen.size(), 752)
    `CHK(seen[0], 8'hb8)
    `CHK(seen[1], 8'h81)
    `CHK(seen[4], 8'h04)
    `CHK(locked, 1'b1)
    `CHK(fs_rises, 1)
    `CHK(fb_rises, 0)
    `CHK(al_rises != 0, 1'b1)
    `CHK(rdy, 1'b1)
    packet(8'h47, 188, 1'b0, 10);
    packet(8'hb8, 188, 1'b0, -1);
    repeat (100) @(posedge ref_clk);
    `CHK(fb_rises, 1)
    `CHK(fs_rises, 2)
    restart(1'b1, 1'b1);
    reg_read(TSF_ADDR_THRESH, d); `CHK(d, TSF_THRESH_RST)
    packet(8'h00, 4, 1'b0, -1);
    packet(8'h00, 2, 1'b0, -1);
    repeat (100) @(posedge ref_clk);
    `CHK(seen.size(), 6)
    `CHK(fs_rises, 0)
    `CHK(locked, 1'b0)
    foreach (exp_forced[j]) `CHK(seen[j], exp_forced[j])
    finish_test();
  end
endmodule // tsf_framer_tb_top

// [tsf_pkg.sv]
// Purpose: Shared constants and types of the transport-stream input framer
// Assumes: Single processing clock domain; pin inputs are synchronised in the top module
// Notes: Register offsets are byte indices of the host register map
package tsf_pkg;

  // Transport packet framing
  localparam logic [7:0] TSF_SYNC_BYTE = 8'h47;     // Ordinary packet sync byte
  localparam logic [7:0] TSF_SYNC_INV = 8'hb8;      // Inverted sync byte at frame head
  localparam logic [7:0] TSF_PKT_LAST = 8'hbb;      // Last byte index of a 188-byte packet
  localparam logic [7:0] TSF_POS_TEI = 8'h01;       // Byte that holds the error-indication bit
  localparam int TSF_TEI_BIT = 7;                   // Error-indication bit inside that byte
  localparam logic [2:0] TSF_PKT_IDX_LAST = 3'h7;   // Eight packets make one sync frame
  localparam logic [2:0] TSF_BIT_LAST = 3'h7;       // Last bit of a serial byte

  // Symbol clock phases (processing clock divided by four)
  localparam logic [1:0] TSF_PH_LAST = 2'h3;        // Phase before phase 0
  localparam logic [1:0] TSF_PH_HIGH_END = 2'h2;    // Symbol clock is high in phases 0 and 1

  // PLL mode pin codes
  localparam logic [1:0] TSF_PLL_NCO = 2'h3;        // Oscillator operation; 2'h0/2'h1 = external PLL

  // Register map
  localparam logic [5:0] TSF_ADDR_THRESH = 6'h2b;   // FIFO measurement threshold
  localparam logic [5:0] TSF_ADDR_STATUS = 6'h2c;   // Framer status
  localparam logic [7:0] TSF_THRESH_RST = 8'h73;    // Threshold reset value

  // Pin group as sampled from the transport source
  typedef struct packed {
    logic clk;        // Input clock pin level
    logic [7:0] data; // Data bus
    logic valid;      // Valid qualifier
    logic err;        // Error flag
    logic pstart;     // Packet-start strobe
    logic srestart;   // Sequence-restart strobe
  } tsf_pins_t;

  // Word held in the input FIFO
  typedef struct packed {
    logic [7:0] data;  // Packet byte
    logic frame_head;  // First byte of an eight-packet sync frame
    logic first;       // Frame head right after a sequence restart
  } tsf_word_t;

  // Sync word tracking states
  typedef enum logic [2:0] {
    TSF_HUNT = 3'b001,
    TSF_TRACK = 3'b010,
    TSF_LOCK = 3'b100
  } tsf_sync_t;

endpackage

// [tsf_ts_source.sv]
// Purpose: Transport source model driving the framer's transport pins
// Assumes: Input clock high for three REF_CLK cycles, low for four or more
// Notes: Input clock stands still low between units
`timescale 1ns/1ps
module tsf_ts_source (
  // Clock and mode
  input wire logic clk,
  input wire logic serial,
  // Transport pins
  output logic ts_clk,
  output logic [7:0] ts_data,
  output logic ts_valid,
  output logic ts_err,
  output logic ts_pstart,
  output logic ts_srestart
);
  // Idle levels at time zero
  initial begin
    ts_clk = 1'b0;
    ts_data = 8'h00;
    ts_valid = 1'b0;
    ts_err = 1'b0;
    ts_pstart = 1'b0;
    ts_srestart = 1'b0;
  end

  // One unit, held from before the rise until the fall
  task automatic unit(input logic [7:0] d, input logic v, ps, er, sr);
    @(posedge clk);
    ts_data <= d;
    ts_valid <= v;
    ts_err <= er;
    ts_pstart <= ps;
    ts_srestart <= sr;
    repeat (3) @(posedge clk);
    ts_clk <= 1'b1;
    repeat (3) @(posedge clk);
    ts_clk <= 1'b0;
  endtask

  // A byte as one unit or eight bits, MSB first, junk on upper bits
  task automatic send(input logic [7:0] d, input logic v, ps, er, sr);
    if (!serial) unit(d, v, ps, er, sr);
    else for (int i = 7; i >= 0; i--) unit({~d[6:0], d[i]}, v, ps && i == 7, er && i == 7, sr);
    @(posedge clk);
    ts_data <= ~ts_data; // Released bus shows no stale byte
    ts_valid <= 1'b0;
  endtask
endmodule // tsf_ts_source
